// File: core/ssr_port.sv
// Purpose: synchronous serial port, master or slave, with AXI4-Lite registers
// Assumes: I_CLOCK at 200 MHz; link clock far slower, sampled by I_CLOCK
// Notes: clock and data pins are split into in, out and output enable
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps

module ssr_port #(
  parameter int ADDR_W = 8
) (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_CK_IN,
  output logic O_CK_OUT,
  output logic O_CK_OE,
  input wire logic I_DT_IN,
  output logic O_DT_OUT,
  output logic O_DT_OE,
  input wire logic I_SLEEP,
  output logic O_WAKE,
  output logic O_ISR_REQ
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ssr_pkg::ssr_txctl_t txc;
  ssr_pkg::ssr_rxctl_t rxc;
  ssr_pkg::ssr_irqen_t irqen;
  logic [15:0] divisor;
  logic sckp;
  logic aw_hold, w_hold;
  logic [ADDR_W-1:0] aw_addr, ar_addr;
  logic [31:0] w_data;
  logic w_lane0, do_write, do_read, wr_ok, rd_ok;
  logic [7:0] rd_byte;
  logic ck_m, ck_s, ck_q, dt_m, dt_s;
  logic sync_on, is_master, is_slave, rx_mode, tx_mode, rx_run;
  logic [15:0] div_cnt;
  logic mphase, mclk_run, tick, lead, trail;
  logic [8:0] hold, transmit_shift_register;
  logic hold_full, tx_busy, tx_wr, tx_last;
  logic [3:0] tx_cnt, rx_cnt, nbits_tx, nbits_rx;
  logic [8:0] receive_shift_register, next_rsr, rx_char;
  logic [8:0] fifo [2];
  logic [1:0] fifo_cnt;
  logic rx_done, pop, push_ok, overrun_evt, overrun_flag, overrun_flag_continuous_receive_enable;
  logic receive_ready_flag, transmit_buffer_flag;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign O_AWREADY = !aw_hold && !O_BVALID;
  assign O_WREADY = !w_hold && !O_BVALID;
  assign O_ARREADY = !O_RVALID;
  assign do_write = aw_hold && w_hold && !O_BVALID;
  assign do_read = I_ARVALID && O_ARREADY;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= ADDR_W'(ssr_pkg::OFF_IRQ_CTRL));
  endfunction

  assign wr_ok = mapped(aw_addr);
  assign rd_ok = mapped(I_ARADDR);

  function automatic logic wr_at(input logic [7:0] off);
    wr_at = do_write && wr_ok && w_lane0 && (aw_addr == ADDR_W'(off));
  endfunction

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= ssr_pkg::RESP_OKAY;
    end else begin
      // address and data are taken in either order
      if (I_AWVALID && O_AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_hold <= 1'b1;
        w_data <= I_WDATA;
        w_lane0 <= I_WSTRB[0];
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= wr_ok ? ssr_pkg::RESP_OKAY : ssr_pkg::RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (I_ARADDR[7:0])
      ssr_pkg::OFF_TX_CTRL: begin
        rd_byte[ssr_pkg::TX_MASTER] = txc.master;
        rd_byte[ssr_pkg::TX_NINE] = txc.nine;
        rd_byte[ssr_pkg::TX_EN] = txc.en;
        rd_byte[ssr_pkg::TX_SYNC] = txc.sync;
        rd_byte[ssr_pkg::TX_EMPTY] = !tx_busy;
        rd_byte[ssr_pkg::TX_NINTH] = txc.ninth;
      end
      ssr_pkg::OFF_RX_CTRL: begin
        rd_byte[ssr_pkg::RX_SERIAL_PORT_ENABLE] = rxc.serial_port_enable;
        rd_byte[ssr_pkg::RX_NINE] = rxc.nine;
        rd_byte[ssr_pkg::RX_SINGLE_RECEIVE_ENABLE] = rxc.single_receive_enable;
        rd_byte[ssr_pkg::RX_CONTINUOUS_RECEIVE_ENABLE] = rxc.continuous_receive_enable;
        rd_byte[ssr_pkg::RX_OVERRUN_FLAG] = overrun_flag;
        rd_byte[ssr_pkg::RX_NINTH] = fifo[0][8];
      end
      ssr_pkg::OFF_RX_DATA: rd_byte = fifo[0][7:0];
      ssr_pkg::OFF_DIV_LO: rd_byte = divisor[7:0];
      ssr_pkg::OFF_DIV_HI: rd_byte = divisor[15:8];
      ssr_pkg::OFF_BAUD_CTRL: begin
        rd_byte[ssr_pkg::BC_IDLE] = (rx_cnt == 4'h0);
        rd_byte[ssr_pkg::BC_SCKP] = sckp;
      end
      ssr_pkg::OFF_IRQ_CTRL: rd_byte = {transmit_buffer_flag, receive_ready_flag, 2'h0, irqen};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ar_addr <= '0;
      O_RVALID <= 1'b0;
      O_RDATA <= '0;
      O_RRESP <= ssr_pkg::RESP_OKAY;
    end else if (do_read) begin
      ar_addr <= I_ARADDR;
      O_RVALID <= 1'b1;
      O_RDATA <= {24'h000000, rd_ok ? rd_byte : 8'h00};
      O_RRESP <= rd_ok ? ssr_pkg::RESP_OKAY : ssr_pkg::RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  assign pop = do_read && (I_ARADDR == ADDR_W'(ssr_pkg::OFF_RX_DATA)) && (fifo_cnt != 2'h0);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      txc <= '0;
      irqen <= '0;
      divisor <= ssr_pkg::DIV_RESET;
      sckp <= 1'b0;
    end else begin
      if (wr_at(ssr_pkg::OFF_TX_CTRL)) begin
        txc <= {w_data[ssr_pkg::TX_MASTER], w_data[ssr_pkg::TX_NINE], w_data[ssr_pkg::TX_EN],
                w_data[ssr_pkg::TX_SYNC], w_data[ssr_pkg::TX_NINTH]};
      end
      if (wr_at(ssr_pkg::OFF_IRQ_CTRL)) begin
        irqen <= w_data[3:0];
      end
      if (wr_at(ssr_pkg::OFF_DIV_LO)) begin
        divisor[7:0] <= w_data[7:0];
      end
      if (wr_at(ssr_pkg::OFF_DIV_HI)) begin
        divisor[15:8] <= w_data[7:0];
      end
      if (wr_at(ssr_pkg::OFF_BAUD_CTRL)) begin
        sckp <= w_data[ssr_pkg::BC_SCKP];
      end
    end
  end

  // hardware clear of single receive comes last so it wins
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rxc <= '0;
    end else begin
      if (wr_at(ssr_pkg::OFF_RX_CTRL)) begin
        rxc <= {w_data[ssr_pkg::RX_SERIAL_PORT_ENABLE], w_data[ssr_pkg::RX_NINE],
                w_data[ssr_pkg::RX_SINGLE_RECEIVE_ENABLE], w_data[ssr_pkg::RX_CONTINUOUS_RECEIVE_ENABLE]};
      end
      if (rx_done && is_master) begin
        rxc.single_receive_enable <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and modes
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ck_m <= 1'b0;
      ck_s <= 1'b0;
      ck_q <= 1'b0;
      dt_m <= 1'b0;
      dt_s <= 1'b0;
    end else begin
      ck_m <= I_CK_IN;
      ck_s <= ck_m;
      ck_q <= ck_s;
      dt_m <= I_DT_IN;
      dt_s <= dt_m;
    end
  end

  assign sync_on = txc.sync && rxc.serial_port_enable;
  assign is_master = sync_on && txc.master;
  assign is_slave = sync_on && !txc.master;
  assign rx_mode = rxc.single_receive_enable || rxc.continuous_receive_enable;
  assign tx_mode = sync_on && !rx_mode && txc.en;
  // slave ignores single enable; blocked in overrun
  assign rx_run = (is_master ? rx_mode : (is_slave && rxc.continuous_receive_enable)) && !overrun_flag;

  // ----------------------------------------------------------------
  // bit clock: master divider or slave edge detection
  // ----------------------------------------------------------------
  assign mclk_run = is_master && ((rx_mode && !overrun_flag) || (tx_mode && tx_busy));
  assign tick = mclk_run && (div_cnt == divisor);

  // clock stops at once when idle
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      div_cnt <= '0;
      mphase <= 1'b0;
    end else if (!mclk_run) begin
      div_cnt <= '0;
      mphase <= 1'b0;
    end else if (tick) begin
      div_cnt <= '0;
      mphase <= !mphase;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // leading edge leaves the idle level, trailing edge returns to it
  always_comb begin
    if (is_master) begin
      lead = tick && !mphase;
      trail = tick && mphase;
    end else begin
      lead = is_slave && ((ck_s ^ sckp) && !(ck_q ^ sckp));
      trail = is_slave && (!(ck_s ^ sckp) && (ck_q ^ sckp));
    end
  end

  // slave leaves the clock line undriven
  assign O_CK_OE = is_master;
  assign O_CK_OUT = mphase ^ sckp;
  assign O_DT_OE = tx_mode;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  assign nbits_tx = txc.nine ? ssr_pkg::BITS_9 : ssr_pkg::BITS_8;
  assign tx_wr = wr_at(ssr_pkg::OFF_TX_DATA) && rxc.serial_port_enable;
  assign tx_last = tx_busy && trail && (tx_cnt == nbits_tx - 4'h1);
  // flag rises only once the held word has moved on or serial_port_enable drops
  assign transmit_buffer_flag = !hold_full;

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      hold <= '0;
      hold_full <= 1'b0;
      transmit_shift_register <= '0;
      tx_busy <= 1'b0;
      tx_cnt <= '0;
      O_DT_OUT <= 1'b0;
    end else if (!rxc.serial_port_enable) begin
      hold_full <= 1'b0;
      tx_busy <= 1'b0;
      tx_cnt <= '0;
    end else begin
      // first word to shifter, second stays held
      if (!tx_busy && hold_full && tx_mode) begin
        transmit_shift_register <= hold;
        tx_busy <= 1'b1;
        tx_cnt <= '0;
        hold_full <= 1'b0;
      end
      if (tx_wr) begin
        hold <= {txc.ninth, w_data[7:0]};
        hold_full <= 1'b1;
      end
      if (tx_busy && lead) begin
        O_DT_OUT <= transmit_shift_register[0];
        transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
      end
      if (tx_busy && trail) begin
        tx_cnt <= tx_cnt + 4'h1;
      end
      if (tx_last || (tx_busy && !tx_mode)) begin
        tx_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver and two-entry FIFO
  // ----------------------------------------------------------------
  // nine bits when enabled
  assign nbits_rx = rxc.nine ? ssr_pkg::BITS_9 : ssr_pkg::BITS_8;
  assign next_rsr = {dt_s, receive_shift_register[8:1]};
  assign rx_done = rx_run && trail && (rx_cnt == nbits_rx - 4'h1);
  assign rx_char = rxc.nine ? next_rsr : {1'b0, next_rsr[8:1]};
  assign overrun_evt = rx_done && (fifo_cnt == ssr_pkg::FIFO_DEPTH) && !pop;
  assign push_ok = rx_done && !overrun_evt;
  assign receive_ready_flag = (fifo_cnt != 2'h0);

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      receive_shift_register <= '0;
      rx_cnt <= '0;
    end else if (!rx_run) begin
      rx_cnt <= '0;
    end else if (trail) begin
      receive_shift_register <= next_rsr;
      rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'h1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fifo[0] <= '0;
      fifo[1] <= '0;
      fifo_cnt <= '0;
    end else if (!rxc.serial_port_enable) begin
      fifo_cnt <= '0;
    end else begin
      case ({push_ok, pop})
        2'b10: begin
          fifo[fifo_cnt[0]] <= rx_char;
          fifo_cnt <= fifo_cnt + 2'h1;
        end
        2'b01: begin
          fifo[0] <= fifo[1];
          fifo_cnt <= fifo_cnt - 2'h1;
        end
        2'b11: begin
          if (fifo_cnt == 2'h1) begin
            fifo[0] <= rx_char;
          end else begin
            fifo[0] <= fifo[1];
            fifo[1] <= rx_char;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // set wins over every clear
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      overrun_flag <= 1'b0;
      overrun_flag_continuous_receive_enable <= 1'b0;
    end else if (overrun_evt) begin
      overrun_flag <= 1'b1;
      overrun_flag_continuous_receive_enable <= rxc.continuous_receive_enable;
    end else if (!rxc.serial_port_enable) begin
      overrun_flag <= 1'b0;
    end else if (overrun_flag_continuous_receive_enable ? !rxc.continuous_receive_enable : pop) begin
      // read clears a single-receive overrun; continuous enable drop clears a continuous one
      overrun_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wake and service requests
  // ----------------------------------------------------------------
  // transmit and receive wake, both only while asleep
  assign O_WAKE = I_SLEEP && irqen.peripheral_irq_enable && ((transmit_buffer_flag && irqen.transmit_irq_enable) || (receive_ready_flag && irqen.receive_irq_enable));
  assign O_ISR_REQ = irqen.global_irq_enable && irqen.peripheral_irq_enable
                     && ((transmit_buffer_flag && irqen.transmit_irq_enable) || (receive_ready_flag && irqen.receive_irq_enable));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  sequence s_last_held;
    tx_last && hold_full && rxc.serial_port_enable;
  endsequence

  sequence s_reload;
    tx_mode && !tx_wr;
  endsequence

  chk_overrun_set: assert property (overrun_evt && rxc.serial_port_enable |=> overrun_flag)
    else $error("overrun not flagged");
  chk_fifo_kept: assert property (overrun_evt && rxc.serial_port_enable |=> $stable(fifo[0]) &&
                                  $stable(fifo[1]) && fifo_cnt == 2'h2)
    else $error("fifo changed on overrun");
  chk_no_accept: assert property (overrun_flag && !pop && rxc.serial_port_enable |=> $stable(fifo_cnt))
    else $error("reception during overrun");
  chk_read_clear: assert property (overrun_flag && !overrun_flag_continuous_receive_enable && pop && !overrun_evt |=> !overrun_flag)
    else $error("overrun not cleared by read");
  chk_continuous_receive_enable_clear: assert property (overrun_flag && overrun_flag_continuous_receive_enable && !rxc.continuous_receive_enable && !overrun_evt |=> !overrun_flag)
    else $error("overrun not cleared by enable drop");
  chk_pop_shift: assert property (pop && !push_ok && fifo_cnt == 2'h2 && rxc.serial_port_enable |=>
                                  fifo_cnt == 2'h1 && fifo[0] == $past(fifo[1]))
    else $error("read did not advance fifo");
  chk_slave_ck_off: assert property (is_slave |-> !O_CK_OE)
    else $error("slave drives clock");
  chk_held_reload: assert property (s_last_held ##1 s_reload |=> tx_busy && transmit_buffer_flag)
    else $error("held word not reloaded");
  chk_single_receive_enable_auto: assert property (rx_done && is_master |=> !rxc.single_receive_enable)
    else $error("single receive not cleared");
  chk_receive_ready_flag_raise: assert property (push_ok && rxc.serial_port_enable |=> receive_ready_flag)
    else $error("ready flag missing");
  chk_trail_sample: assert property (rx_run && trail |=>
                                     receive_shift_register == {$past(dt_s), $past(receive_shift_register[8:1])})
    else $error("sample not shifted");
  chk_mclk_stop: assert property (!mclk_run |=> !mphase && div_cnt == 16'h0000)
    else $error("master clock kept running");

endmodule

// File: pkg/ssr_pkg.sv
// Purpose: shared constants and types of the synchronous serial port
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: registers are 8 bits wide and sit in the low byte of each word
package ssr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TX_CTRL = 8'h00;
  localparam logic [7:0] OFF_RX_CTRL = 8'h04;
  localparam logic [7:0] OFF_RX_DATA = 8'h08;
  localparam logic [7:0] OFF_TX_DATA = 8'h0c;
  localparam logic [7:0] OFF_DIV_LO = 8'h10;
  localparam logic [7:0] OFF_DIV_HI = 8'h14;
  localparam logic [7:0] OFF_BAUD_CTRL = 8'h18;
  localparam logic [7:0] OFF_IRQ_CTRL = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TX_MASTER = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_EMPTY = 1;
  localparam int TX_NINTH = 0;
  localparam int RX_SERIAL_PORT_ENABLE = 7;
  localparam int RX_NINE = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RX_OVERRUN_FLAG = 1;
  localparam int RX_NINTH = 0;
  localparam int BC_IDLE = 6;
  localparam int BC_SCKP = 4;
  localparam int IQ_RECEIVE_IRQ_ENABLE = 0;
  localparam int IQ_TRANSMIT_IRQ_ENABLE = 1;
  localparam int IQ_PERIPHERAL_IRQ_ENABLE = 2;
  localparam int IQ_GIE = 3;
  localparam int IQ_RECEIVE_READY_FLAG = 6;
  localparam int IQ_TRANSMIT_BUFFER_FLAG = 7;

  // ----------------------------------------------------------------
  // values and sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef struct packed {
    logic master;
    logic nine;
    logic en;
    logic sync;
    logic ninth;
  } ssr_txctl_t;

  typedef struct packed {
    logic serial_port_enable;
    logic nine;
    logic single_receive_enable;
    logic continuous_receive_enable;
  } ssr_rxctl_t;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic transmit_irq_enable;
    logic receive_irq_enable;
  } ssr_irqen_t;

endpackage

// File: test/ssr_ext_master.sv
// Purpose: external synchronous master that clocks the port as slave
// Assumes: idle clock low, link half period 24 ns
// Notes: data line released after a frame shows the inverse of its last bit
`timescale 1ns/100ps
module ssr_ext_master (
  output logic o_ck,
  output logic o_dt,
  input wire logic i_dt
);
  initial begin
    o_ck = 1'b0;
    o_dt = 1'b0;
  end

  task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    // keep the first pin change off the sampling edge
    #1;
    for (int i = 0; i < n; i++) begin
      o_ck = 1'b1;
      o_dt = tx[i];
      #24;
      o_ck = 1'b0;
      rx[i] = i_dt;
      #24;
    end
    // clock stands still, line no longer holds the bit
    o_dt = ~o_dt;
  endtask

  // static data level while the port is clock master
  task automatic level(input logic v);
    #1;
    o_dt = v;
  endtask
endmodule

// File: test/ssr_port_tb.sv
// Purpose: self-checking bench of the synchronous serial port in slave and master mode
// Assumes: idle clock level low, AXI4-Lite master tasks below
// Notes: slave scenarios use the partner model; master receive holds the data line
`timescale 1ns/100ps
module ssr_port_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, slp = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] br, rr;
  logic awr, wrdy, bv, arr, rv, ck_o, ck_oe, dt_o, dt_oe, wake, isr, m_ck, m_dt;
  logic [8:0] got;
  int num_errors = 0, n_tests = 0;
  wire logic ck = ck_oe ? ck_o : m_ck;
  wire logic dt = dt_oe ? dt_o : m_dt;

  always #2.5 clk = ~clk;

  ssr_port u_ssr_port (.I_CLOCK(clk), .I_RSTN(rstn), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hf),
    .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
    .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdat), .O_RRESP(rr),
    .I_CK_IN(ck), .O_CK_OUT(ck_o), .O_CK_OE(ck_oe), .I_DT_IN(dt), .O_DT_OUT(dt_o),
    .O_DT_OE(dt_oe), .I_SLEEP(slp), .O_WAKE(wake), .O_ISR_REQ(isr));
  ssr_ext_master u_ext (.o_ck(m_ck), .o_dt(m_dt), .i_dt(dt));

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= {24'h0, d};
    // second pass only confirms both items are gone
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (awv || wv);
    bry <= 1'b1;
    do @(negedge clk); while (!bv);
    chk("write resp", {30'h0, ssr_pkg::RESP_OKAY}, {30'h0, br});
    @(posedge clk);
    bry <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    d = rdat;
    r = rr;
    @(posedge clk);
    rry <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    bus_rd(a, d, r);
    chk(nm, {24'h0, e}, d);
  endtask

  task automatic send(input logic [8:0] v, input int n);
    u_ext.xfer(v, n, got);
    repeat (10) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    bus_rd(8'h20, d, r);
    chk("unmapped resp", {30'h0, ssr_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    $display("test bus done");
  endtask

  task automatic t_overrun;
    bus_wr(ssr_pkg::OFF_TX_CTRL, 8'h10);
    bus_wr(ssr_pkg::OFF_IRQ_CTRL, 8'h05);
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'h90);
    @(posedge clk);
    slp <= 1'b1;
    send(9'h0a5, 8);
    chk("wake on receive", 32'h1, {31'h0, wake});
    send(9'h03c, 8);
    send(9'h077, 8);
    rchk(ssr_pkg::OFF_RX_CTRL, 8'h92, "overrun set");
    rchk(ssr_pkg::OFF_RX_DATA, 8'ha5, "first kept");
    rchk(ssr_pkg::OFF_RX_DATA, 8'h3c, "second kept");
    send(9'h011, 8);
    rchk(ssr_pkg::OFF_RX_CTRL, 8'h92, "overrun held");
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'h80);
    rchk(ssr_pkg::OFF_RX_CTRL, 8'h80, "overrun cleared");
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'h90);
    send(9'h05a, 8);
    rchk(ssr_pkg::OFF_RX_DATA, 8'h5a, "after clear");
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'h00);
    slp <= 1'b0;
    $display("test overrun done");
  endtask

  task automatic t_nine;
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'hc0);
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'hd0);
    send(9'h1c3, 9);
    send(9'h022, 9);
    rchk(ssr_pkg::OFF_RX_CTRL, 8'hd1, "ninth bit first");
    rchk(ssr_pkg::OFF_RX_DATA, 8'hc3, "nine bit low");
    rchk(ssr_pkg::OFF_RX_CTRL, 8'hd0, "ninth bit next");
    rchk(ssr_pkg::OFF_RX_DATA, 8'h22, "second low");
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'h00);
    $display("test nine done");
  endtask

  task automatic t_tx;
    bus_wr(ssr_pkg::OFF_TX_CTRL, 8'h71);
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'h80);
    bus_wr(ssr_pkg::OFF_IRQ_CTRL, 8'h0e);
    @(posedge clk);
    slp <= 1'b1;
    bus_wr(ssr_pkg::OFF_TX_DATA, 8'h96);
    bus_wr(ssr_pkg::OFF_TX_DATA, 8'h4b);
    rchk(ssr_pkg::OFF_IRQ_CTRL, 8'h0e, "flag held low");
    chk("data driver", 32'h1, {31'h0, dt_oe});
    chk("clock driver", 32'h0, {31'h0, ck_oe});
    send(9'h000, 9);
    chk("first word", 32'h196, {23'h0, got});
    chk("wake on flag", 32'h1, {31'h0, wake});
    chk("service", 32'h1, {31'h0, isr});
    rchk(ssr_pkg::OFF_IRQ_CTRL, 8'h8e, "flag set");
    send(9'h000, 9);
    chk("second word", 32'h14b, {23'h0, got});
    rchk(ssr_pkg::OFF_TX_CTRL, 8'h73, "shifter empty");
    slp <= 1'b0;
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'h00);
    $display("test transmit done");
  endtask

  task automatic t_master;
    bus_wr(ssr_pkg::OFF_DIV_LO, 8'h03);
    bus_wr(ssr_pkg::OFF_TX_CTRL, 8'h90);
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'h80);
    chk("master clock driver", 32'h1, {31'h0, ck_oe});
    u_ext.level(1'b1);
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'ha0);
    repeat (80) @(posedge clk);
    rchk(ssr_pkg::OFF_RX_CTRL, 8'h80, "single receive ends");
    chk("clock idle", 32'h0, {31'h0, ck_o});
    u_ext.level(1'b0);
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'ha0);
    repeat (80) @(posedge clk);
    u_ext.level(1'b1);
    bus_wr(ssr_pkg::OFF_RX_CTRL, 8'ha0);
    repeat (80) @(posedge clk);
    rchk(ssr_pkg::OFF_RX_CTRL, 8'h82, "single overrun");
    rchk(ssr_pkg::OFF_RX_DATA, 8'hff, "master first");
    rchk(ssr_pkg::OFF_RX_CTRL, 8'h80, "read clears");
    rchk(ssr_pkg::OFF_RX_DATA, 8'h00, "master second");
    $display("test master done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_bus;
    t_overrun;
    t_nine;
    t_tx;
    t_master;
    results;
  end

  // whole run needs a few microseconds
  initial begin
    #200000;
    num_errors++;
    results;
  end
endmodule
